/* File: tap_ctrl.sv */
// Test access port controller, instruction and data registers
`default_nettype none
module tap_ctrl
  import tap_pkg::*;
#(
  parameter int unsigned BSC_W = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo_o,
  output logic                     tdo_oe,
  input  wire logic                test_port_enable_fuse,
  input  wire logic                test_port_disable_bit,
  output logic                     port_active,
  output logic                     pullup_en,
  output logic [IR_W-1:0]          instr_out,
  output logic [BSC_W-1:0]         bsc_update,
  input  wire logic [BSC_W-1:0]    bsc_capture,
  output logic [CHAIN_W-1:0]       prog_update,
  input  wire logic [CHAIN_W-1:0]  prog_capture,
  output logic [CHAIN_W-1:0]       int_update,
  input  wire logic [CHAIN_W-1:0]  int_capture,
  output logic [CHAIN_W-1:0]       brk_update,
  input  wire logic [CHAIN_W-1:0]  brk_capture,
  output logic                     upd_valid,
  input  wire logic                upd_ready,
  output logic [BSC_W-1:0]         upd_data,
  output logic                     run_idle,
  output logic [3:0]               tap_state_o
);
  // Elaboration check: the boundary chain must fit the shared shift register
  if (BSC_W < 1 || BSC_W > ID_W) begin : g_bad_bsc_w
    $error("BSC_W out of range");
  end

  localparam int unsigned SH_W = ID_W;

  // Synchronised pins; test clock edges found by sys_clk
  // Only the edges of the test clock matter, never its level
  logic tck_rise, tck_fall;
  logic tms_lvl, tdi_lvl, en_lvl, dis_lvl;

  tap_sync u_sync_tck (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(tck),
                       .level_out(), .rise_out(tck_rise), .fall_out(tck_fall));
  tap_sync u_sync_tms (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(tms),
                       .level_out(tms_lvl), .rise_out(), .fall_out());
  tap_sync u_sync_tdi (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(tdi),
                       .level_out(tdi_lvl), .rise_out(), .fall_out());
  tap_sync u_sync_en  (.sys_clk(sys_clk), .reset_n(reset_n),
                       .async_in(test_port_enable_fuse),
                       .level_out(en_lvl), .rise_out(), .fall_out());
  tap_sync u_sync_dis (.sys_clk(sys_clk), .reset_n(reset_n),
                       .async_in(test_port_disable_bit),
                       .level_out(dis_lvl), .rise_out(), .fall_out());

  typedef struct packed {
    tap_state_t        state;
    logic [IR_W-1:0]   ir_sh;
    logic [IR_W-1:0]   ir;
    logic [SH_W-1:0]   dr_sh;
    logic              tdo;
    logic              tdo_oe;
    logic              active;
    logic [BSC_W-1:0]  bsc;
    logic [CHAIN_W-1:0] prog;
    logic [CHAIN_W-1:0] intc;
    logic [CHAIN_W-1:0] brk;
    logic              push;
    logic [BSC_W-1:0]  push_data;
    logic              idle;
  } ctrl_st_t;
  ctrl_st_t st_r;
  ctrl_st_t st_nxt;

  // Next-state table of the sixteen-state controller
  function automatic tap_state_t next_state(input tap_state_t s, input logic m);
    case (s)
      ST_RESET:  next_state = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = m ? ST_SEL_DR : ST_IDLE;
      default:   next_state = ST_RESET;
    endcase
  endfunction

  // Length of the data path picked by an instruction
  function automatic int unsigned dr_len(input logic [IR_W-1:0] op, input int unsigned bw);
    case (op)
      OP_IDCODE:                         dr_len = ID_W;
      OP_EXTEST, OP_SAMPLE:              dr_len = bw;
      OP_PROG, OP_INTSCAN, OP_BRKSCAN:   dr_len = CHAIN_W;
      default:                           dr_len = 1;   // Bypass and unknown codes
    endcase
  endfunction

  int unsigned cur_len;
  logic        shifting;
  assign cur_len = dr_len(st_r.ir, BSC_W);

  always_comb begin
    st_nxt      = st_r;
    st_nxt.push = 1'b0;
    shifting    = 1'b0;
    st_nxt.active = en_lvl & ~dis_lvl;
    if (!en_lvl) begin
      // Fuse off: controller held in reset, pins left to the port logic
      st_nxt.state  = ST_RESET;
      st_nxt.ir     = IR_RESET_VAL;
      st_nxt.tdo_oe = 1'b0;
    end else if (tck_rise && st_r.active) begin
      st_nxt.state = next_state(st_r.state, tms_lvl);
      case (st_r.state)
        ST_RESET: begin
          st_nxt.ir = IR_RESET_VAL;
        end
        ST_CAP_IR: begin
          st_nxt.ir_sh = IR_CAPTURE;
        end
        ST_SH_IR: begin
          // Low bit leaves first, new bit enters at the top
          st_nxt.ir_sh = {tdi_lvl, st_r.ir_sh[IR_W-1:1]};
        end
        ST_CAP_DR: begin
          st_nxt.dr_sh = '0;
          case (st_r.ir)
            OP_IDCODE:            st_nxt.dr_sh = ID_VALUE;
            OP_EXTEST, OP_SAMPLE: st_nxt.dr_sh[BSC_W-1:0] = bsc_capture;
            OP_PROG:              st_nxt.dr_sh[CHAIN_W-1:0] = prog_capture;
            OP_INTSCAN:           st_nxt.dr_sh[CHAIN_W-1:0] = int_capture;
            OP_BRKSCAN:           st_nxt.dr_sh[CHAIN_W-1:0] = brk_capture;
            default:              st_nxt.dr_sh = '0;
          endcase
        end
        ST_SH_DR: begin
          shifting     = 1'b1;
          st_nxt.dr_sh = st_r.dr_sh >> 1;
          st_nxt.dr_sh[cur_len-1] = tdi_lvl;
        end
        ST_UPD_DR: begin
          // Latched outputs move only here
          case (st_r.ir)
            OP_EXTEST: begin
              st_nxt.bsc       = st_r.dr_sh[BSC_W-1:0];
              st_nxt.push      = 1'b1;
              st_nxt.push_data = st_r.dr_sh[BSC_W-1:0];
            end
            OP_PROG:    st_nxt.prog = st_r.dr_sh[CHAIN_W-1:0];
            OP_INTSCAN: st_nxt.intc = st_r.dr_sh[CHAIN_W-1:0];
            OP_BRKSCAN: st_nxt.brk  = st_r.dr_sh[CHAIN_W-1:0];
            default:    st_nxt.bsc  = st_r.bsc;
          endcase
        end
        ST_UPD_IR: begin
          st_nxt.ir = st_r.ir_sh;
        end
        // Exit, pause and exit2 states only navigate
        default: st_nxt.ir = st_r.ir;
      endcase
      // Instruction falls back to bypass as Test-Logic-Reset is entered
      if (st_nxt.state == ST_RESET) begin
        st_nxt.ir = IR_RESET_VAL;
      end
    end else if (tck_fall) begin
      // Output changes on the falling test clock; it is enabled only in shift states
      st_nxt.tdo_oe = st_r.active &&
                      (st_r.state == ST_SH_IR || st_r.state == ST_SH_DR);
      st_nxt.tdo    = (st_r.state == ST_SH_IR) ? st_r.ir_sh[0] : st_r.dr_sh[0];
    end
    if (!st_r.active) begin
      st_nxt.tdo_oe = 1'b0;
    end
    // Idle flag registered so the output comes from a flop
    st_nxt.idle = (st_nxt.state == ST_IDLE);
  end

  // Async reset is power-on reset; no separate test reset exists
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= '0;
      st_r.state <= ST_RESET;
      st_r.ir    <= IR_RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Boundary updates queued two deep; a push while both entries are full is dropped
  logic buf_ready;
  tap_buf #(.W(BSC_W)) u_buf (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .in_valid (st_r.push),
    .in_ready (buf_ready),
    .in_data  (st_r.push_data),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data (upd_data)
  );

  assign tdo_o       = st_r.tdo;
  assign tdo_oe      = st_r.tdo_oe;
  assign port_active = st_r.active;
  assign pullup_en   = st_r.active;
  assign instr_out   = st_r.ir;
  assign bsc_update  = st_r.bsc;
  assign prog_update = st_r.prog;
  assign int_update  = st_r.intc;
  assign brk_update  = st_r.brk;
  assign run_idle    = st_r.idle;
  assign tap_state_o = st_r.state;

  AST_IR_UPDATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_r.active && tck_rise && st_r.state != ST_UPD_IR
     && next_state(st_r.state, tms_lvl) != ST_RESET
     && en_lvl) |=> $stable(st_r.ir)) else $error("instruction changed outside update");
  AST_CAP_IR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (en_lvl && st_r.active && tck_rise && st_r.state == ST_CAP_IR)
    |=> st_r.ir_sh == IR_CAPTURE) else $error("capture pattern wrong");
  AST_FUSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !en_lvl |=> st_r.state == ST_RESET && !tdo_oe) else $error("fuse off not reset");
  AST_TDO_OE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(tdo_oe) |-> $past(tck_fall)) else $error("tdo enabled off falling edge");
  AST_TLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (en_lvl && st_r.active && tck_rise && tms_lvl && st_r.state == ST_SEL_IR)
    |=> st_r.state == ST_RESET) else $error("reset path broken");
  AST_ACTIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 port_active == $past(en_lvl & ~dis_lvl)) else $error("port enable wrong");
  AST_SHIFT_DR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (shifting && cur_len > 1) |=> st_r.dr_sh[0] == $past(st_r.dr_sh[1]))
    else $error("dr not shifting lsb first");
  AST_DR_UPD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $changed(st_r.prog) |-> $past(st_r.state) == ST_UPD_DR) else $error("prog latched early");
  // Boundary word and its queued copy move together, only out of Update-DR
  AST_PUSH_UPD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st_r.push |-> $past(st_r.state) == ST_UPD_DR) else $error("update word pushed early");
  AST_BSC_UPD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $changed(st_r.bsc) |-> $past(st_r.state) == ST_UPD_DR) else $error("boundary latched early");
  AST_PAUSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (en_lvl && st_r.active && tck_rise
     && st_r.state inside {ST_EX1_DR, ST_PAU_DR, ST_EX2_DR}) |=> $stable(st_r.dr_sh))
    else $error("data shifted outside shift state");
  AST_TDO_SHIFT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(tdo_oe) |-> $past(st_r.state == ST_SH_IR || st_r.state == ST_SH_DR))
    else $error("tdo driven outside shift states");
  AST_TLR_IR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st_r.state == ST_RESET |-> st_r.ir == IR_RESET_VAL) else $error("instruction not reset");
  COV_SHIFT_IR: cover property (@(posedge sys_clk) st_r.state == ST_SH_IR);
  COV_TLR:      cover property (@(posedge sys_clk) st_r.state == ST_SEL_IR ##1 st_r.state == ST_RESET);
  COV_DIRECT:   cover property (@(posedge sys_clk) st_r.state == ST_UPD_IR ##1 st_r.state == ST_SEL_DR);
  COV_UPD_DR:   cover property (@(posedge sys_clk) st_r.state == ST_UPD_DR);
  COV_FULL:     cover property (@(posedge sys_clk) !buf_ready);
endmodule
`default_nettype wire

/* File: tap_pkg.sv */
// Constants and types shared by the test access port logic
`default_nettype none
package tap_pkg;
  localparam int unsigned IR_W      = 4;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  localparam logic [3:0]  IR_RESET_VAL = 4'hf;   // Bypass after reset
  localparam logic [3:0]  OP_EXTEST  = 4'h0;
  localparam logic [3:0]  OP_IDCODE  = 4'h1;
  localparam logic [3:0]  OP_SAMPLE  = 4'h2;
  localparam logic [3:0]  OP_PROG    = 4'h4;
  localparam logic [3:0]  OP_INTSCAN = 4'h8;
  localparam logic [3:0]  OP_BRKSCAN = 4'h9;
  localparam logic [3:0]  OP_BYPASS  = 4'hf;
  localparam logic [31:0] ID_VALUE   = 32'h0000_0001; // Arbitrary neutral value
  localparam int unsigned ID_W = 32;
  localparam int unsigned CHAIN_W = 8;              // Width of the local scan chains

  typedef enum logic [3:0] {
    ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h2, ST_CAP_DR  = 4'h3,
    ST_SH_DR   = 4'h4, ST_EX1_DR  = 4'h5, ST_PAU_DR  = 4'h6, ST_EX2_DR  = 4'h7,
    ST_UPD_DR  = 4'h8, ST_SEL_IR  = 4'h9, ST_CAP_IR  = 4'ha, ST_SH_IR   = 4'hb,
    ST_EX1_IR  = 4'hc, ST_PAU_IR  = 4'hd, ST_EX2_IR  = 4'he, ST_UPD_IR  = 4'hf
  } tap_state_t;
endpackage
`default_nettype wire

/* File: tap_sync.sv */
// Two-stage synchroniser with rise and fall pulses
`default_nettype none
module tap_sync
  import tap_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_st_t;
  sync_st_t st_r;
  sync_st_t st_nxt;

  // First stage is read only by the second
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = async_in;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.sync;
  assign rise_out  = st_r.sync & ~st_r.last;
  assign fall_out  = ~st_r.sync & st_r.last;
endmodule
`default_nettype wire

/* File: tap_buf.sv */
// Two-entry valid/ready buffer for update data words
`default_nettype none
module tap_buf
  import tap_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  // Elaboration check: an empty word cannot be stored
  if (W < 1) begin : g_bad_w
    $error("tap_buf width must be positive");
  end

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } buf_st_t;
  buf_st_t st_r;
  buf_st_t st_nxt;

  // Pointer FIFO; ready falls when both entries hold words
  always_comb begin
    st_nxt = st_r;
    if (in_valid && in_ready) begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr           = ~st_r.wr;
    end
    if (out_valid && out_ready) begin
      st_nxt.rd = ~st_r.rd;
    end
    st_nxt.cnt = st_r.cnt + 2'((in_valid && in_ready) ? 1 : 0)
                          - 2'((out_valid && out_ready) ? 1 : 0);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready  = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data  = st_r.mem[st_r.rd];
endmodule
`default_nettype wire

/* File: jtag_host_model.sv */
// Behavioural model of the external scan controller driving the test port
`default_nettype none
module jtag_host_model (
  input  wire logic   sys_clk,
  input  wire logic   tdo_o,
  input  wire logic   tdo_oe,
  input  wire logic   pullup_en,
  output logic        tck,
  output logic        tms,
  output logic        tdi,
  output logic [31:0] rx_word
);
  timeunit 1ns;
  timeprecision 100ps;

  event rx_ev;
  logic tdo_line;

  // Released line sits at the pull-up, else shows the opposite of the last bit
  assign tdo_line = tdo_oe ? tdo_o : (pullup_en ? 1'b1 : ~tdo_o);

  // Test clock parks high between frames
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    rx_word = '0;
  end

  // One test-clock period, 170 ns back to back; TDO read late in the low phase
  task automatic bit_cyc(input logic m, input logic d, output logic q);
    @(posedge sys_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge sys_clk);
    q = tdo_line;
    tck <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  // Mode-select pattern, first level in bit 0
  task automatic walk(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      bit_cyc(seq[i], 1'b0, q);
    end
  endtask

  // Shift n bits low bit first; mode-select rises with the last bit
  task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
    logic q;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    rx_word = dout;
    -> rx_ev;
  endtask
endmodule
`default_nettype wire

/* File: test_jtag_tap_controller.sv */
// Self-checking bench for the test access port controller
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_jtag_tap_controller
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BW = 8;
  localparam logic [3:0] OPS [4] = '{OP_SAMPLE, OP_PROG, OP_INTSCAN, OP_BRKSCAN};

  logic        sys_clk, reset_n, tck, tms, tdi, tdo_o, tdo_oe, fuse, dis;
  logic        port_active, pullup_en, upd_valid, upd_ready, run_idle;
  logic [3:0]  instr_out, tap_state_o;
  logic [7:0]  bsc_update, bsc_capture, prog_update, prog_capture, upd_data;
  logic [7:0]  int_update, int_capture, brk_update, brk_capture, u_w;
  logic [31:0] rx_word, e_w, r;
  logic [31:0] exp_q [$];
  logic [7:0]  upd_q [$];
  int          n_fail, checks, seed;

  tap_ctrl #(.BSC_W(BW)) tap_ctrl_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .test_port_enable_fuse(fuse),
    .test_port_disable_bit(dis), .port_active(port_active), .pullup_en(pullup_en),
    .instr_out(instr_out), .bsc_update(bsc_update), .bsc_capture(bsc_capture),
    .prog_update(prog_update), .prog_capture(prog_capture), .int_update(int_update),
    .int_capture(int_capture), .brk_update(brk_update), .brk_capture(brk_capture),
    .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_data(upd_data),
    .run_idle(run_idle), .tap_state_o(tap_state_o));

  jtag_host_model jtag_host_model_inst (
    .sys_clk(sys_clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .pullup_en(pullup_en),
    .tck(tck), .tms(tms), .tdi(tdi), .rx_word(rx_word));

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0 && exp_q.size() == 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] cap_of(input logic [3:0] op);
    case (op)
      OP_PROG:    return prog_capture;
      OP_INTSCAN: return int_capture;
      OP_BRKSCAN: return brk_capture;
      default:    return bsc_capture;
    endcase
  endfunction

  function automatic logic [7:0] upd_of(input logic [3:0] op);
    case (op)
      OP_PROG:    return prog_update;
      OP_INTSCAN: return int_update;
      OP_BRKSCAN: return brk_update;
      default:    return bsc_update;
    endcase
  endfunction

  // Fresh parallel inputs, settled before the next capture
  task automatic randcap();
    @(posedge sys_clk);
    bsc_capture  <= 8'($random(seed));
    prog_capture <= 8'($random(seed));
    int_capture  <= 8'($random(seed));
    brk_capture  <= 8'($random(seed));
    @(posedge sys_clk);
  endtask

  // Load an instruction; direct leaves the port in Shift-DR without idling
  task automatic ir(input logic [3:0] op, input logic direct);
    logic [31:0] d;
    jtag_host_model_inst.walk(8'h03, 4);
    exp_q.push_back(32'(IR_CAPTURE));
    jtag_host_model_inst.shift(32'(op), IR_W, d);
    if (direct) jtag_host_model_inst.walk(8'h03, 4);
    else jtag_host_model_inst.walk(8'h01, 2);
    `CHK(instr_out, op)
  endtask

  // Data scan through pause; latched outputs must hold until Update-DR
  task automatic dr(input logic [3:0] op, input logic [31:0] din, input int n,
                    input logic [31:0] ex, input logic walk_in);
    logic [31:0] d;
    logic [7:0]  prev;
    prev = upd_of(op);
    if (walk_in) jtag_host_model_inst.walk(8'h01, 3);
    exp_q.push_back(ex);
    jtag_host_model_inst.shift(din, n, d);
    jtag_host_model_inst.walk(8'h00, 1);
    `CHK(tap_state_o, ST_PAU_DR)
    if (op inside {OP_EXTEST, OP_PROG, OP_INTSCAN, OP_BRKSCAN}) `CHK(upd_of(op), prev)
    jtag_host_model_inst.walk(8'h03, 3);
    if (op inside {OP_EXTEST, OP_PROG, OP_INTSCAN, OP_BRKSCAN}) `CHK(upd_of(op), din[7:0])
  endtask

  // Every scanned-out word against the oldest note; wait for the port copy to settle
  always begin
    @(jtag_host_model_inst.rx_ev);
    #1;
    e_w = exp_q.pop_front();
    `CHK(rx_word, e_w)
  end

  // Buffered update words leave in order when accepted
  always @(posedge sys_clk) begin
    if (upd_valid === 1'b1 && upd_ready) begin
      u_w = upd_q.pop_front();
      `CHK(upd_data, u_w)
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    seed = 32'h89a7;
    n_fail = 0;
    checks = 0;
    {reset_n, dis, bsc_capture, prog_capture, int_capture, brk_capture} = '0;
    {fuse, upd_ready} = 2'b11;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK(tap_state_o, ST_RESET)
    `CHK(instr_out, IR_RESET_VAL)
    `CHK({port_active, pullup_en}, 2'b11)
    jtag_host_model_inst.walk(8'h00, 1);
    `CHK(run_idle, 1'b1)
    `CHK(tdo_oe, 1'b0)
    ir(OP_IDCODE, 1'b0);
    dr(OP_IDCODE, 32'h0, ID_W, ID_VALUE, 1'b1);
    ir(OP_BYPASS, 1'b0);
    r = $random(seed);
    dr(OP_BYPASS, r, BW, {24'h0, r[6:0], 1'b0}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      randcap();
      r = $random(seed);
      ir(OPS[i], i[0]);
      dr(OPS[i], r, BW, {24'h0, cap_of(OPS[i])}, !i[0]);
    end
    // Receiver stalls while two update words queue up
    @(posedge sys_clk) upd_ready <= 1'b0;
    ir(OP_EXTEST, 1'b0);
    for (int i = 0; i < 2; i++) begin
      randcap();
      r = $random(seed);
      upd_q.push_back(r[7:0]);
      dr(OP_EXTEST, r, BW, {24'h0, bsc_capture}, 1'b1);
    end
    `CHK(upd_valid, 1'b1)
    @(posedge sys_clk) upd_ready <= 1'b1;
    for (int k = 0; k < 20 && upd_q.size() != 0; k++) @(posedge sys_clk);
    if (upd_q.size() != 0) begin
      n_fail++;
      stop_test();
    end
    @(posedge sys_clk);
    `CHK(upd_valid, 1'b0)
    // Five high periods from deep in the data branch; passing Update-DR under
    // the boundary instruction queues the captured word, shifted once with a 0
    upd_q.push_back({1'b0, bsc_capture[7:1]});
    jtag_host_model_inst.walk(8'h01, 3);
    jtag_host_model_inst.walk(8'h1f, 5);
    `CHK(tap_state_o, ST_RESET)
    `CHK(instr_out, IR_RESET_VAL)
    // Unprogrammed fuse pins the controller in reset
    @(posedge sys_clk) fuse <= 1'b0;
    jtag_host_model_inst.walk(8'h00, 2);
    `CHK(tap_state_o, ST_RESET)
    `CHK({port_active, pullup_en, tdo_oe}, 3'b000)
    @(posedge sys_clk) {fuse, dis} <= 2'b11;
    repeat (10) @(posedge sys_clk);
    `CHK(port_active, 1'b0)
    @(posedge sys_clk) dis <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK(port_active, 1'b1)
    // Debugger pulls the system reset low in mid-run, with an instruction loaded
    jtag_host_model_inst.walk(8'h00, 1);
    ir(OP_PROG, 1'b0);
    @(posedge sys_clk) reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK(tap_state_o, ST_RESET)
    `CHK(instr_out, IR_RESET_VAL)
    jtag_host_model_inst.walk(8'h00, 1);
    `CHK(run_idle, 1'b1)
    stop_test();
  end
endmodule
`default_nettype wire
